// >>> common/sstg_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the snapshot
 * time and gain register bank.
 * Assumes inclusion by the package and by the register bank, once each.
 */
`ifndef SSTG_PARAMS_SVH
`define SSTG_PARAMS_SVH

// register offsets on the serial control register port
`define SSTG_OFF_SNAP_HIGH 8'h31
`define SSTG_OFF_SNAP_LOW 8'h32
`define SSTG_OFF_BLK_CTRL 8'h40
`define SSTG_OFF_BLK_TARGET 8'h41
`define SSTG_OFF_GAIN 8'h42
`define SSTG_OFF_BLK_OFFSET 8'h43
`define SSTG_OFF_CHAN_MAP 8'h4A

// field positions
`define SSTG_BLK_DISABLE_BIT 3
`define SSTG_BLK_RATE_MSB 2
`define SSTG_BLK_RATE_LSB 0
`define SSTG_GAIN_MSB 6
`define SSTG_SNAP_LOW_MSB 6
`define SSTG_MAP0_MSB 7
`define SSTG_MAP0_LSB 6
`define SSTG_MAP1_MSB 5
`define SSTG_MAP1_LSB 4
`define SSTG_MAP2_MSB 3
`define SSTG_MAP2_LSB 2
`define SSTG_MAP3_MSB 1
`define SSTG_MAP3_LSB 0

// reset values
`define SSTG_RST_SNAP_HIGH 8'h00
`define SSTG_RST_SNAP_LOW 7'h00
`define SSTG_RST_BLK_CTRL 4'h0
`define SSTG_RST_BLK_TARGET 8'h00
`define SSTG_RST_GAIN 7'h00
`define SSTG_RST_BLK_OFFSET 8'h00
`define SSTG_RST_CHAN_MAP 8'h1B

// answer on an unmapped address
`define SSTG_UNMAPPED_DATA 8'h00

// capture timer counts one clock per unit of capture time
`define SSTG_SNAP_ZERO 15'h0000
`define SSTG_SNAP_ONE 15'h0001

`endif

// >>> common/sstg_pkg.sv
/*
 * Types shared by the snapshot time and gain register bank.
 * Assumes sstg_params.svh sits beside it on the include path.
 */
`include "sstg_params.svh"

package sstg_pkg;

	typedef logic [7:0] sstg_byte_t;
	typedef logic [14:0] sstg_snap_time_t;
	typedef logic [1:0] sstg_map_t;

	typedef enum logic [0:0]
	{
		SSTG_IDLE,
		SSTG_EXPOSE
	} sstg_snap_state_t;

endpackage

// >>> design/sstg_dbuf_reg.sv
/*
 * One double-buffered register: host writes land in a shadow copy, which
 * moves to the active copy only on a commit strobe.
 * Assumes commit and write come from logic on the same clock.
 */
`timescale 1ns/1ps

module sstg_dbuf_reg
	import sstg_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	// clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// host side
	input wire logic wr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] shadow,
	// frame side
	input wire logic commit,
	output logic [WIDTH-1:0] active
);

	logic [WIDTH-1:0] shadow_q;
	logic [WIDTH-1:0] active_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			shadow_q <= RESET_VAL;
		else if (ce && wr)
			shadow_q <= wdata;
	end

	// a commit in the cycle of a write takes the older shadow; the write waits a frame
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			active_q <= RESET_VAL;
		else if (ce && commit)
			active_q <= shadow_q;
	end

	assign shadow = shadow_q;
	assign active = active_q;

endmodule

// >>> design/sstg_regs.sv
/*
 * Snapshot capture time, black level and gain register bank, with the
 * snapshot capture timer that drives the external sync pulse.
 * Assumes the serial control decoder and frame timing share clk.
 */
// Behaviour
// - capture time bits 14:7 held read/write at 0x31.
// - capture time bits 6:0 at 0x32 bits 6:0; bit 7 reserved.
// - zero capture time: no external sync pulse, image readout still starts.
// - bit 3 of 0x40 set disables automatic black compensation; zero enables.
// - bits 2:0 of 0x40 select the black loop convergence rate.
// - eight-bit black level target held read/write at 0x41.
// - seven-bit analog gain code at 0x42, reset zero, 0.125 dB steps.
// - eight-bit read/write manual black offset register.
// - channel map 0x4A: four two-bit channel fields, reset 0x1B.
`timescale 1ns/1ps
`include "sstg_params.svh"

module sstg_regs
	import sstg_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// register port from the serial control decoder
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// frame timing
	input wire logic frame_start,
	input wire logic snap_start,
	output logic ext_sync,
	output logic readout_start,
	output logic snap_busy,
	output logic [14:0] snap_capture_time,
	// analog settings
	output logic black_comp_enable,
	output logic [2:0] black_loop_rate,
	output logic [7:0] black_target_value,
	output logic [6:0] analog_gain,
	output logic [7:0] manual_black_offset,
	output logic [1:0] channel_zero_map,
	output logic [1:0] channel_one_map,
	output logic [1:0] channel_two_map,
	output logic [1:0] channel_three_map
);

	////////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
		addr_hit = (addr == off);
	endfunction

	wire logic hit_snap_high = addr_hit(reg_addr, `SSTG_OFF_SNAP_HIGH);
	wire logic hit_snap_low = addr_hit(reg_addr, `SSTG_OFF_SNAP_LOW);
	wire logic hit_blk_ctrl = addr_hit(reg_addr, `SSTG_OFF_BLK_CTRL);
	wire logic hit_blk_target = addr_hit(reg_addr, `SSTG_OFF_BLK_TARGET);
	wire logic hit_gain = addr_hit(reg_addr, `SSTG_OFF_GAIN);
	wire logic hit_blk_offset = addr_hit(reg_addr, `SSTG_OFF_BLK_OFFSET);
	wire logic hit_chan_map = addr_hit(reg_addr, `SSTG_OFF_CHAN_MAP);

	wire logic wr_en = ce && reg_wr;

	////////////////////////////////////////////////////////////////////////////
	// double-buffered capture time

	logic [7:0] snap_high_shadow;
	logic [7:0] snap_high_active;
	logic [6:0] snap_low_shadow;
	logic [6:0] snap_low_active;

	sstg_dbuf_reg #(
		.WIDTH(8),
		.RESET_VAL(`SSTG_RST_SNAP_HIGH)
	) u_snap_high (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.wr(reg_wr && hit_snap_high),
		.wdata(reg_wdata),
		.shadow(snap_high_shadow),
		.commit(frame_start),
		.active(snap_high_active)
	);

	// lower capture time bits, bit 7 dropped
	sstg_dbuf_reg #(
		.WIDTH(7),
		.RESET_VAL(`SSTG_RST_SNAP_LOW)
	) u_snap_low (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.wr(reg_wr && hit_snap_low),
		.wdata(reg_wdata[`SSTG_SNAP_LOW_MSB:0]),
		.shadow(snap_low_shadow),
		.commit(frame_start),
		.active(snap_low_active)
	);

	// both halves share one commit strobe
	assign snap_capture_time = {snap_high_active, snap_low_active};

	////////////////////////////////////////////////////////////////////////////
	// plain registers

	logic [3:0] blk_ctrl_q;
	logic [7:0] blk_target_q;
	logic [6:0] gain_q;
	logic [7:0] blk_offset_q;
	logic [7:0] chan_map_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			blk_ctrl_q <= `SSTG_RST_BLK_CTRL;
		else if (wr_en && hit_blk_ctrl)
			blk_ctrl_q <= reg_wdata[`SSTG_BLK_DISABLE_BIT:0];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			blk_target_q <= `SSTG_RST_BLK_TARGET;
		else if (wr_en && hit_blk_target)
			blk_target_q <= reg_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			gain_q <= `SSTG_RST_GAIN;
		else if (wr_en && hit_gain)
			gain_q <= reg_wdata[`SSTG_GAIN_MSB:0];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			blk_offset_q <= `SSTG_RST_BLK_OFFSET;
		else if (wr_en && hit_blk_offset)
			blk_offset_q <= reg_wdata;
	end

	// channel map; a monochrome host clears it after reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			chan_map_q <= `SSTG_RST_CHAN_MAP;
		else if (wr_en && hit_chan_map)
			chan_map_q <= reg_wdata;
	end

	// active-high disable turned into an enable
	assign black_comp_enable = !blk_ctrl_q[`SSTG_BLK_DISABLE_BIT];
	assign black_loop_rate = blk_ctrl_q[`SSTG_BLK_RATE_MSB:`SSTG_BLK_RATE_LSB];
	assign black_target_value = blk_target_q;
	assign analog_gain = gain_q;
	assign manual_black_offset = blk_offset_q;
	assign channel_zero_map = chan_map_q[`SSTG_MAP0_MSB:`SSTG_MAP0_LSB];
	assign channel_one_map = chan_map_q[`SSTG_MAP1_MSB:`SSTG_MAP1_LSB];
	assign channel_two_map = chan_map_q[`SSTG_MAP2_MSB:`SSTG_MAP2_LSB];
	assign channel_three_map = chan_map_q[`SSTG_MAP3_MSB:`SSTG_MAP3_LSB];

	////////////////////////////////////////////////////////////////////////////
	// read-back; snapshot registers return the shadow, i.e. what the host wrote

	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	assign rdata_d = hit_snap_high ? snap_high_shadow :
		hit_snap_low ? {1'b0, snap_low_shadow} :
		hit_blk_ctrl ? {4'h0, blk_ctrl_q} :
		hit_blk_target ? blk_target_q :
		hit_gain ? {1'b0, gain_q} :
		hit_blk_offset ? blk_offset_q :
		hit_chan_map ? chan_map_q :
		`SSTG_UNMAPPED_DATA;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_q <= `SSTG_UNMAPPED_DATA;
		else if (ce && reg_rd)
			rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// snapshot capture timer: one clock per unit of capture time

	sstg_snap_state_t state_q;
	sstg_snap_state_t state_d;
	logic [14:0] count_q;
	logic [14:0] count_d;
	logic sync_q;
	logic sync_d;
	logic readout_q;
	logic readout_d;

	wire logic snap_zero = (snap_capture_time == `SSTG_SNAP_ZERO);
	wire logic count_last = (count_q == `SSTG_SNAP_ONE);
	wire logic snap_take = (state_q == SSTG_IDLE) && snap_start;

	always_comb
	begin
		state_d = state_q;
		count_d = count_q;
		sync_d = sync_q;
		readout_d = 1'b0;
		case (state_q)
			SSTG_IDLE:
			begin
				if (snap_start)
				begin
					// zero time skips the sync pulse but still reads out
					if (snap_zero)
						readout_d = 1'b1;
					else
					begin
						state_d = SSTG_EXPOSE;
						count_d = snap_capture_time;
						sync_d = 1'b1;
					end
				end
			end
			SSTG_EXPOSE:
			begin
				count_d = count_q - `SSTG_SNAP_ONE;
				if (count_last)
				begin
					state_d = SSTG_IDLE;
					sync_d = 1'b0;
					readout_d = 1'b1;
				end
			end
			default:
			begin
				state_d = SSTG_IDLE;
				sync_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= SSTG_IDLE;
			count_q <= `SSTG_SNAP_ZERO;
			sync_q <= 1'b0;
			readout_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			count_q <= count_d;
			sync_q <= sync_d;
			readout_q <= readout_d;
		end
	end

	assign ext_sync = sync_q;
	assign readout_start = readout_q;
	assign snap_busy = (state_q != SSTG_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence seq_write_high;
		ce && reg_wr && hit_snap_high;
	endsequence

	sequence seq_read_high;
		ce && reg_rd && hit_snap_high && !reg_wr;
	endsequence

	chk_high_readback: assert property (
		seq_write_high ##1 seq_read_high |=> reg_rdata == $past(reg_wdata, 2))
		else $error("capture time high read-back differs from write");

	chk_low_reserved: assert property (
		ce && reg_rd && hit_snap_low |=> reg_rdata[7] == 1'b0 &&
			reg_rdata[6:0] == $past(snap_low_shadow))
		else $error("capture time low read-back wrong");

	chk_zero_nosync: assert property (
		ce && snap_take && snap_zero |=> !ext_sync && readout_start)
		else $error("zero capture time gave sync or no readout");

	chk_nonzero_sync: assert property (
		ce && snap_take && !snap_zero |=> ext_sync && !readout_start &&
			count_q == $past(snap_capture_time))
		else $error("nonzero capture time gave no sync");

	chk_sync_end: assert property (
		ce && ext_sync && count_last |=> !ext_sync && readout_start)
		else $error("sync did not end with readout");

	chk_blk_disable: assert property (
		wr_en && hit_blk_ctrl |=> black_comp_enable == !$past(reg_wdata[3]))
		else $error("black compensation enable wrong");

	chk_blk_rate: assert property (
		wr_en && hit_blk_ctrl |=> black_loop_rate == $past(reg_wdata[2:0]))
		else $error("black loop rate wrong");

	chk_blk_target: assert property (
		wr_en && hit_blk_target |=> black_target_value == $past(reg_wdata))
		else $error("black target wrong");

	chk_gain_code: assert property (
		wr_en && hit_gain |=> analog_gain == $past(reg_wdata[6:0]))
		else $error("analog gain code wrong");

	chk_offset_value: assert property (
		wr_en && hit_blk_offset |=> manual_black_offset == $past(reg_wdata))
		else $error("manual black offset wrong");

	chk_map_fields: assert property (
		wr_en && hit_chan_map |=> channel_zero_map == $past(reg_wdata[7:6]) &&
			channel_three_map == $past(reg_wdata[1:0]))
		else $error("channel map fields wrong");

	chk_snap_commit: assert property (
		ce && frame_start |=> snap_capture_time ==
			$past({snap_high_shadow, snap_low_shadow}))
		else $error("capture time not applied at frame start");

	chk_snap_hold: assert property (
		!(ce && frame_start) |=> $stable(snap_capture_time))
		else $error("capture time changed outside frame start");

endmodule

// >>> bench/sstg_host_model.sv
/*
 * Host controller model on the register port: writes, reads, monochrome setup.
 * Assumes one clock; strobes are taken on the rising edge after they are set.
 */
`timescale 1ns/1ps

module sstg_host_model
(
	// clock
	input wire logic clk,
	// register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// released lines show the inverse so a stale value cannot pass
		reg_addr <= ~a;
		reg_wdata <= ~d;
		// return past the landing edge so callers never see pre-update outputs
		#1;
	endtask

	// write then read back to back
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
		q = reg_rdata;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask

	task automatic mono();
		wr(8'h4A, 8'h00);
	endtask
endmodule

// >>> bench/snapshot_time_and_gain_regs_tb_top.sv
/*
 * Self-checking bench for the snapshot time and gain register bank.
 * Assumes sstg_regs and its package are compiled first; one 100 MHz clock.
 */
`timescale 1ns/1ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module snapshot_time_and_gain_regs_tb_top;
	logic clk, rst_n, ce, frame_start, snap_start;
	logic reg_wr, reg_rd, ext_sync, readout_start, snap_busy, black_comp_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, black_target_value, manual_black_offset;
	logic [14:0] snap_capture_time;
	logic [2:0] black_loop_rate;
	logic [6:0] analog_gain;
	logic [1:0] channel_zero_map, channel_one_map, channel_two_map, channel_three_map;
	logic [7:0] map_all;
	assign map_all = {channel_zero_map, channel_one_map, channel_two_map, channel_three_map};
	logic [7:0] rv;
	int fails = 0;
	int comparisons = 0;
	// last entry is an unmapped address
	logic [7:0] adr [8] = '{8'h31, 8'h32, 8'h40, 8'h41, 8'h42, 8'h43, 8'h4A, 8'h33};
	logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1B, 8'h00};
	logic [7:0] ff_v [8] = '{8'hFF, 8'h7F, 8'h0F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h00};

	sstg_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	sstg_regs DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .snap_start(snap_start), .ext_sync(ext_sync),
		.readout_start(readout_start), .snap_busy(snap_busy),
		.snap_capture_time(snap_capture_time), .black_comp_enable(black_comp_enable),
		.black_loop_rate(black_loop_rate), .black_target_value(black_target_value),
		.analog_gain(analog_gain), .manual_black_offset(manual_black_offset),
		.channel_zero_map(channel_zero_map), .channel_one_map(channel_one_map),
		.channel_two_map(channel_two_map), .channel_three_map(channel_three_map));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic commit();
		@(posedge clk);
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		#1;
	endtask

	// runs one snapshot and counts the cycles that sync and busy stay high
	task automatic snap(input int t);
		int hits;
		int busies;
		int i;
		hits = 0;
		busies = 0;
		@(posedge clk);
		snap_start <= 1'b1;
		@(posedge clk);
		snap_start <= 1'b0;
		// look one step after each edge, never in the launching time step
		for (i = 0; i < 64; i++)
		begin
			#1;
			if (readout_start === 1'b1)
				break;
			hits += (ext_sync === 1'b1);
			busies += (snap_busy === 1'b1);
			@(posedge clk);
		end
		if (i == 64)
		begin
			fails++;
			report_and_stop();
		end
		`CHK(hits, t)
		`CHK(busies, t)
		`CHK(ext_sync, 1'b0)
		`CHK(snap_busy, 1'b0)
		@(posedge clk);
		#1;
		`CHK(readout_start, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		frame_start = 1'b0;
		snap_start = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			host.rd(adr[k], rv);
			`CHK(rv, rst_v[k])
		end
		`CHK(black_comp_enable, 1'b1)
		`CHK(analog_gain, 7'h00)
		`CHK(map_all, 8'h1B)
		$display("test reset values done");
		for (int k = 0; k < 8; k++)
		begin
			host.wr(adr[k], 8'hFF);
			host.rd(adr[k], rv);
			`CHK(rv, ff_v[k])
		end
		`CHK(black_comp_enable, 1'b0)
		`CHK(black_loop_rate, 3'h7)
		`CHK(black_target_value, 8'hFF)
		`CHK(analog_gain, 7'h7F)
		`CHK(manual_black_offset, 8'hFF)
		`CHK({channel_zero_map, channel_three_map}, 4'hF)
		host.wr(8'h40, 8'h05);
		host.wr(8'h4A, 8'hE4);
		`CHK({black_comp_enable, black_loop_rate}, 4'hD)
		`CHK(map_all, 8'hE4)
		// a write while ce is low is not taken
		@(posedge clk);
		ce <= 1'b0;
		host.wr(8'h42, 8'h11);
		@(posedge clk);
		ce <= 1'b1;
		#1;
		`CHK(analog_gain, 7'h7F)
		$display("test field access done");
		`CHK(snap_capture_time, 15'h0000)
		host.wr_rd(8'h31, 8'h5A, rv);
		`CHK(rv, 8'h5A)
		host.wr(8'h31, 8'h12);
		host.wr(8'h32, 8'h34);
		`CHK(snap_capture_time, 15'h0000)
		host.rd(8'h31, rv);
		`CHK(rv, 8'h12)
		commit();
		`CHK(snap_capture_time, {8'h12, 7'h34})
		$display("test double buffer done");
		host.wr(8'h31, 8'h00);
		host.wr(8'h32, 8'h03);
		commit();
		snap(3);
		host.wr(8'h32, 8'h00);
		commit();
		snap(0);
		$display("test snapshot done");
		host.mono();
		host.rd(8'h4A, rv);
		`CHK(rv, 8'h00)
		`CHK({channel_zero_map, channel_three_map}, 4'h0)
		$display("test monochrome done");
		report_and_stop();
	end
endmodule
